// ---- hdl/ppa_pkg.sv ----
`default_nettype none
package ppa_pkg;
    // Channel count and level width (hundredths of a physical unit, signed)
    localparam int NUM_CH = 3;
    localparam int VAL_W  = 24;
    localparam int TYPE_W = 4;

    // Accepted level range in hundredths: -999.00 .. 9990.00
    localparam logic signed [VAL_W-1:0] LEVEL_MIN = -24'sd99900;
    localparam logic signed [VAL_W-1:0] LEVEL_MAX = 24'sd999000;

    // Register offsets (byte addresses)
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_TYPE  = 8'h00;
    localparam logic [7:0] OFS_UPPER = 8'h04;
    localparam logic [7:0] OFS_LOWER = 8'h08;
    localparam logic [7:0] OFS_LIVE  = 8'h30;
    localparam logic [7:0] OFS_EVENT = 8'h34;
    localparam logic [7:0] OFS_MASK  = 8'h38;

    // Level register fields
    localparam int LEVEL_OFF_BIT = 24;

    // Reset values
    localparam logic [TYPE_W-1:0]       TYPE_RST  = 4'h0;
    localparam logic                    OFF_RST   = 1'b1;
    localparam logic signed [VAL_W-1:0] LEVEL_RST = 24'sh000000;
    localparam logic [NUM_CH-1:0]       MASK_RST  = 3'h0;

    // Alarm type code fields: [3:2] source, [1] latch, [0] hold
    localparam logic [1:0] SRC_PV_ABS = 2'h0;
    localparam logic [1:0] SRC_PV_DEV = 2'h1;
    localparam logic [1:0] SRC_SV_ABS = 2'h2;
    localparam logic [1:0] SRC_MV_ABS = 2'h3;

    // Controller variables of one PID controller
    typedef struct packed {
        logic signed [VAL_W-1:0] command;     // process_command_value
        logic signed [VAL_W-1:0] feedback;    // feedback_value
        logic signed [VAL_W-1:0] manipulated; // manipulated_value
    } ppa_proc_t;

    // Alarm settings of one channel
    typedef struct packed {
        logic [TYPE_W-1:0]       alarm_type;
        logic                    upper_off;
        logic signed [VAL_W-1:0] upper;
        logic                    lower_off;
        logic signed [VAL_W-1:0] lower;
    } ppa_cfg_t;
endpackage
`default_nettype wire

// ---- hdl/ppa_channel.sv ----
`default_nettype none
module ppa_channel (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    // Settings and controller variables
    input  wire ppa_pkg::ppa_cfg_t   cfg_i,
    input  wire ppa_pkg::ppa_proc_t  proc_i,
    input  wire logic                reset_cmd_i,
    // Alarm output
    output logic                     alarm_o
);
    import ppa_pkg::*;

    logic [1:0]            src;
    logic                  hold_sel;
    logic                  latch_sel;
    logic signed [VAL_W:0] mon;
    logic signed [VAL_W:0] lo_lim;
    logic signed [VAL_W:0] hi_lim;
    logic                  below;
    logic                  above;
    logic                  in_range;
    logic                  armed;
    logic                  latched;
    logic                  next_alarm;

    // Code fields
    assign src       = cfg_i.alarm_type[3:2];
    assign hold_sel  = cfg_i.alarm_type[0];
    assign latch_sel = cfg_i.alarm_type[1];

    // Monitored quantity and limits, one bit wider so sums never wrap
    always_comb begin
        mon    = {proc_i.feedback[VAL_W-1], proc_i.feedback};
        lo_lim = {cfg_i.lower[VAL_W-1], cfg_i.lower};
        hi_lim = {cfg_i.upper[VAL_W-1], cfg_i.upper};
        if (src == SRC_PV_DEV) begin
            lo_lim = {proc_i.command[VAL_W-1], proc_i.command}
                     - {cfg_i.lower[VAL_W-1], cfg_i.lower};
            hi_lim = {proc_i.command[VAL_W-1], proc_i.command}
                     + {cfg_i.upper[VAL_W-1], cfg_i.upper};
        end else if (src == SRC_SV_ABS) begin
            mon = {proc_i.command[VAL_W-1], proc_i.command};
        end else if (src == SRC_MV_ABS) begin
            mon = {proc_i.manipulated[VAL_W-1], proc_i.manipulated};
        end
    end

    // Band test; an OFF side never contributes
    assign below    = !cfg_i.lower_off && (mon < lo_lim);
    assign above    = !cfg_i.upper_off && (hi_lim < mon);
    assign in_range = below || above;

    // Hold arming: cleared at power-on, set once a hold type sees the quantity inside the range
    // Both levels OFF defines no range, so settings still arriving cannot arm it early
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed <= 1'b0;
        end else if (hold_sel && !in_range && !(cfg_i.upper_off && cfg_i.lower_off)) begin
            armed <= 1'b1;
        end
    end

    // Latch: kept until the reset command
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latched <= 1'b0;
        end else if (reset_cmd_i) begin
            latched <= 1'b0;
        end else if (latch_sel && next_alarm) begin
            latched <= 1'b1;
        end
    end

    assign next_alarm = (in_range && (armed || !hold_sel))
                        || (latch_sel && latched && !reset_cmd_i);

    // Registered alarm output
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alarm_o <= 1'b0;
        end else begin
            alarm_o <= next_alarm;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ppa_top.sv ----
// The placing of the registers and strobed register access were chosen for this implementation.
`default_nettype none
module ppa_top (
    // Clock and reset
    input  wire logic                                  clk_i,
    input  wire logic                                  arst_n_i,
    // Register port
    input  wire logic [7:0]                            addr_i,
    input  wire logic [31:0]                           wdata_i,
    input  wire logic                                  wr_i,
    input  wire logic                                  rd_i,
    output logic      [31:0]                           rdata_o,
    // Controller variables and reset command from drive logic
    input  wire ppa_pkg::ppa_proc_t [ppa_pkg::NUM_CH-1:0] proc_i,
    input  wire logic                                  reset_cmd_i,
    // Alarm outputs
    output logic                                       pid1_process_alarm_out_o,
    output logic                                       pid2_process_alarm_out_o,
    output logic                                       pid3_process_alarm_out_o,
    // Interrupt
    output logic                                       irq_o
);
    import ppa_pkg::*;

    ppa_cfg_t [NUM_CH-1:0]    cfg;
    logic     [NUM_CH-1:0]    alarm;
    logic     [NUM_CH-1:0]    alarm_prev;
    logic     [NUM_CH-1:0]    event_sts;
    logic     [NUM_CH-1:0]    mask;
    logic     [NUM_CH-1:0]    rise;
    logic     [31:0]          next_rdata;
    logic signed [VAL_W-1:0]  wval;
    logic                     wval_ok;
    logic                     wr_off;

    // Level write decode: OFF flag or in-range value
    assign wval    = wdata_i[VAL_W-1:0];
    assign wr_off  = wdata_i[LEVEL_OFF_BIT];
    assign wval_ok = wr_off || ((wval >= LEVEL_MIN) && (wval <= LEVEL_MAX));

    // Per-channel settings and alarm logic
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            localparam logic [7:0] BASE = 8'(ch * CH_STRIDE);

            // Type code register
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    cfg[ch].alarm_type <= TYPE_RST;
                end else if (wr_i && addr_i == BASE + OFS_TYPE) begin
                    cfg[ch].alarm_type <= wdata_i[TYPE_W-1:0];
                end
            end

            // Upper level register; out-of-range writes are ignored
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    cfg[ch].upper_off <= OFF_RST;
                    cfg[ch].upper     <= LEVEL_RST;
                end else if (wr_i && addr_i == BASE + OFS_UPPER && wval_ok) begin
                    cfg[ch].upper_off <= wr_off;
                    cfg[ch].upper     <= wval;
                end
            end

            // Lower level register; out-of-range writes are ignored
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    cfg[ch].lower_off <= OFF_RST;
                    cfg[ch].lower     <= LEVEL_RST;
                end else if (wr_i && addr_i == BASE + OFS_LOWER && wval_ok) begin
                    cfg[ch].lower_off <= wr_off;
                    cfg[ch].lower     <= wval;
                end
            end

            // Comparator, hold and latch of this channel
            ppa_channel u_chan (
                .clk_i       (clk_i),
                .arst_n_i    (arst_n_i),
                .cfg_i       (cfg[ch]),
                .proc_i      (proc_i[ch]),
                .reset_cmd_i (reset_cmd_i),
                .alarm_o     (alarm[ch])
            );
        end
    endgenerate

    // Alarm outputs, each straight from its channel's flop
    assign pid1_process_alarm_out_o = alarm[0];
    assign pid2_process_alarm_out_o = alarm[1];
    assign pid3_process_alarm_out_o = alarm[2];

    // Edge history for alarm turn-on events
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alarm_prev <= '0;
        end else begin
            alarm_prev <= alarm;
        end
    end

    assign rise = alarm & ~alarm_prev;

    // Sticky event bits, write one to clear; a new event wins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            event_sts <= '0;
        end else if (wr_i && addr_i == OFS_EVENT) begin
            event_sts <= (event_sts & ~wdata_i[NUM_CH-1:0]) | rise;
        end else begin
            event_sts <= event_sts | rise;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask <= MASK_RST;
        end else if (wr_i && addr_i == OFS_MASK) begin
            mask <= wdata_i[NUM_CH-1:0];
        end
    end

    // Level interrupt, registered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(event_sts & mask);
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_i == OFS_LIVE) begin
            next_rdata = 32'(alarm);
        end else if (addr_i == OFS_EVENT) begin
            next_rdata = 32'(event_sts);
        end else if (addr_i == OFS_MASK) begin
            next_rdata = 32'(mask);
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_i == 8'(i * CH_STRIDE) + OFS_TYPE) begin
                    next_rdata = 32'(cfg[i].alarm_type);
                end else if (addr_i == 8'(i * CH_STRIDE) + OFS_UPPER) begin
                    next_rdata = {7'h00, cfg[i].upper_off, cfg[i].upper};
                end else if (addr_i == 8'(i * CH_STRIDE) + OFS_LOWER) begin
                    next_rdata = {7'h00, cfg[i].lower_off, cfg[i].lower};
                end
            end
        end
    end

    // Read data, valid in the cycle after the read strobe only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- tb/ppa_alarm_mon.sv ----
`default_nettype none
module ppa_alarm_mon #(
    parameter logic [2:0] INV = 3'h0
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Alarm outputs seen at the terminals
    input  wire logic [2:0] alarm_i,
    output logic      [2:0] term_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Terminal level, inverted where negative logic is assigned
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) term_o <= INV;
        else term_o <= alarm_i ^ INV;
    end
endmodule
`default_nettype wire

// ---- tb/ppa_top_chk.sv ----
`default_nettype none
module ppa_top_chk (
    // Clock and reset
    input wire logic                                    clk_i,
    input wire logic                                    arst_n_i,
    // Register port
    input wire logic [7:0]                              addr_i,
    input wire logic                                    wr_i,
    input wire logic                                    rd_i,
    input wire logic [31:0]                             rdata_o,
    // Controller side
    input wire ppa_pkg::ppa_proc_t [ppa_pkg::NUM_CH-1:0] proc_i,
    input wire logic                                    reset_cmd_i,
    // Outputs
    input wire logic                                    pid1_process_alarm_out_o,
    input wire logic                                    pid2_process_alarm_out_o,
    input wire logic                                    pid3_process_alarm_out_o,
    input wire logic                                    irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import ppa_pkg::*;
    logic [2:0] alm;
    logic [2:0] alm_q;
    logic       ev;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Alarm vector and a rising-alarm or write event
    assign alm = {pid3_process_alarm_out_o, pid2_process_alarm_out_o, pid1_process_alarm_out_o};
    assign ev  = wr_i || (|(alm & ~alm_q));
    // Previous alarms
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) alm_q <= 3'h0;
        else alm_q <= alm;
    end
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
    AST_QUIET: assert property (disable iff (1'b0) !arst_n_i |-> alm == 3'h0 && !irq_o)
        else $error("outputs active in reset");
    AST_LIVE: assert property (rd_i && addr_i == 8'h30 |=>
        rdata_o == {29'h0, $past(alm)}) else $error("live alarm readback wrong");
    AST_UNMAP: assert property (rd_i && addr_i == 8'h3c |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    AST_RISE_CAUSE: assert property ($rose(pid1_process_alarm_out_o) |->
        $past(proc_i[0]) != $past(proc_i[0], 2) || $past(wr_i) || $past(wr_i, 2))
        else $error("alarm rose without cause");
    AST_FALL_CAUSE: assert property ($fell(pid2_process_alarm_out_o) |->
        $past(proc_i[1]) != $past(proc_i[1], 2) || $past(wr_i) || $past(wr_i, 2)
        || $past(reset_cmd_i) || $past(reset_cmd_i, 2)) else $error("alarm fell without cause");
    AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
        else $error("irq rose without event");
    AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3))
        else $error("irq fell without write");
    COV_ALARM: cover property ($rose(pid1_process_alarm_out_o));
    COV_IRQ: cover property ($rose(irq_o));
    COV_RELEASE: cover property (reset_cmd_i && pid2_process_alarm_out_o);
endmodule
bind ppa_top ppa_top_chk i_ppa_top_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .proc_i(proc_i), .reset_cmd_i(reset_cmd_i),
    .pid1_process_alarm_out_o(pid1_process_alarm_out_o),
    .pid2_process_alarm_out_o(pid2_process_alarm_out_o),
    .pid3_process_alarm_out_o(pid3_process_alarm_out_o), .irq_o(irq_o));
`default_nettype wire

// ---- tb/tb_ppa_top.sv ----
`default_nettype none
module tb_ppa_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ppa_pkg::*;
    typedef struct packed {
        logic [3:0]  code;
        logic [31:0] up;
        logic [31:0] lo;
        logic [23:0] q;
        logic        exp;
    } ppa_row_t;
    localparam logic [31:0] UP = 32'h000003e8;
    localparam logic [31:0] LO = 32'h00fffc18;
    localparam logic [31:0] OF = 32'h01000000;
    localparam logic [23:0] BG = 24'h07a120;
    localparam logic [31:0] MX = 32'h000f3e58;
    // Code, upper, lower, monitored value, expected alarm
    localparam ppa_row_t ROWS [19] = '{
        '{4'h0, UP, LO, 24'h0003e9, 1'b1}, '{4'h0, UP, LO, 24'h0003e8, 1'b0},
        '{4'h1, UP, LO, 24'hfffc17, 1'b1}, '{4'h2, UP, LO, 24'hfffc18, 1'b0},
        '{4'h3, OF, LO, 24'h001388, 1'b0}, '{4'h4, UP, UP, 24'h00044d, 1'b1},
        '{4'h5, UP, UP, 24'h00044c, 1'b0}, '{4'h6, UP, UP, 24'hfffc7b, 1'b1},
        '{4'h7, UP, OF, 24'hffec78, 1'b0}, '{4'h8, UP, LO, 24'h0003e9, 1'b1},
        '{4'h9, UP, LO, 24'hfffc17, 1'b1}, '{4'ha, OF, OF, 24'hffec78, 1'b0},
        '{4'hb, UP, LO, 24'h0003e8, 1'b0}, '{4'hc, 32'h000f3e58, 32'h00fe79c4, 24'h0f3e59, 1'b1},
        '{4'hd, UP, 32'h00fe79c4, 24'hfe79c3, 1'b1}, '{4'he, UP, LO, 24'h0003e9, 1'b1},
        '{4'hf, UP, LO, 24'h000000, 1'b0}, '{4'h4, UP, MX, 24'h00044d, 1'b1},
        '{4'h4, MX, UP, 24'hfffc7b, 1'b1}};
    logic                    clk, arst_n, wr_s, rd_s, rcmd;
    logic [7:0]              addr;
    logic [31:0]             wdata, d;
    wire logic [31:0]        rdata;
    wire logic [2:0]         alm, term;
    wire logic               irq;
    ppa_proc_t [NUM_CH-1:0]  proc;
    ppa_row_t                r;
    int                      n_errors, num_checks, cyc;
    ppa_top i_ppa_top (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .proc_i(proc), .reset_cmd_i(rcmd),
        .pid1_process_alarm_out_o(alm[0]), .pid2_process_alarm_out_o(alm[1]),
        .pid3_process_alarm_out_o(alm[2]), .irq_o(irq));
    ppa_alarm_mon #(.INV(3'h1)) i_ppa_alarm_mon (.clk_i(clk), .arst_n_i(arst_n),
        .alarm_i(alm), .term_o(term));
    always #20 clk = ~clk;
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a; wdata <= v; wr_s <= 1'b1;
        @(posedge clk); wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a; rd_s <= 1'b1;
        @(posedge clk); rd_s <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic rst_cmd();
        rcmd <= 1'b1;
        @(posedge clk); rcmd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        cycles(8);
        ck("alarms in reset", 32'h0, {29'h0, alm});
        arst_n <= 1'b1;
        @(posedge clk);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        clk = 0; arst_n = 1; wr_s = 0; rd_s = 0; rcmd = 0; addr = 0; wdata = 0; proc = '0;
        do_reset();
        // Table: arm inside the range, then apply the row value
        for (int i = 0; i < 19; i++) begin
            r = ROWS[i];
            wr(8'(16 * (i % 3)), {28'h0, r.code});
            wr(8'(16 * (i % 3) + 4), r.up);
            wr(8'(16 * (i % 3) + 8), r.lo);
            proc[i % 3] <= '{command: 24'h64, feedback: 24'h64, manipulated: 24'h0};
            rst_cmd();
            cycles(2);
            proc[i % 3] <= '{command: r.code[3:2] == 2 ? r.q : (r.code[3:2] == 1 ? 24'h64 : BG),
                feedback: r.code[3:2] < 2 ? r.q : BG, manipulated: r.code[3:2] == 3 ? r.q : BG};
            cycles(3);
            ck("row alarm", {31'h0, r.exp}, {31'h0, alm[i % 3]});
            rd(8'h30);
            ck("row live", {31'h0, r.exp}, {31'h0, d[i % 3]});
        end
        // Power-on again: defaults, hold and latch
        proc <= '{'{24'h0, 24'h32, 24'h0}, '{24'h96, 24'h0, 24'h0}, '{24'h0, 24'h32, 24'h0}};
        do_reset();
        rd(8'h20); ck("type reset", 32'h0, d);
        rd(8'h24); ck("upper reset", OF, d);
        rd(8'h38); ck("mask reset", 32'h0, d);
        wr(8'h00, 32'h1); wr(8'h08, 32'h64); cycles(3);
        ck("hold quiet", 32'h0, {31'h0, alm[0]});
        proc[0].feedback <= 24'h96; cycles(3);
        ck("hold armed", 32'h0, {31'h0, alm[0]});
        proc[0].feedback <= 24'h32; cycles(3);
        ck("hold alarm", 32'h1, {31'h0, alm[0]});
        ck("inverted terminal", 32'h0, {31'h0, term[0]});
        wr(8'h10, 32'ha); wr(8'h18, 32'h64); proc[1].command <= 24'h32; cycles(3);
        ck("latch on", 32'h1, {31'h0, alm[1]});
        proc[1].command <= 24'h96; cycles(3);
        ck("latch kept", 32'h1, {31'h0, alm[1]});
        rst_cmd(); cycles(2);
        ck("latch released", 32'h0, {31'h0, alm[1]});
        // Events, mask and interrupt
        rd(8'h34); ck("events", 32'h3, d);
        ck("irq masked", 32'h0, {31'h0, irq});
        wr(8'h38, 32'h2); cycles(2); ck("irq on", 32'h1, {31'h0, irq});
        wr(8'h34, 32'h2); cycles(2); ck("irq off", 32'h0, {31'h0, irq});
        rd(8'h34); ck("events cleared", 32'h1, d);
        // Refused levels and unmapped place
        wr(8'h24, 32'h000f3e59); rd(8'h24); ck("upper refused", OF, d);
        wr(8'h28, 32'h00fe79c3); rd(8'h28); ck("lower refused", OF, d);
        wr(8'h3c, 32'hffffffff); rd(8'h3c); ck("unmapped", 32'h0, d);
        summarize();
    end
endmodule
`default_nettype wire
